// ==== rss_consts.svh ====
/*
 constants for the reset and sleep sequencer: option word layout, timing
 figures and cycle counts. assumes a 200 MHz system clock.
*/
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH

// ----------------------------------------------------------------------
// option word
// ----------------------------------------------------------------------
`define RSS_OPT_ADDR 16'h2007
`define RSS_OPT_SPACE_LO 16'h2000
`define RSS_OPT_SPACE_HI 16'h3fff
`define RSS_OPT_W 14
`define RSS_OPT_ERASED 14'h07ff
`define RSS_OPT_RSVD_MASK 14'h07f8
`define RSS_OPT_USED_MASK 14'h0007
`define RSS_OPT_RST_BIT 2
`define RSS_OPT_MODE_HI 1
`define RSS_OPT_MODE_LO 0

// ----------------------------------------------------------------------
// oscillator mode codes
// ----------------------------------------------------------------------
`define RSS_MODE_HS 2'h3
`define RSS_MODE_EC 2'h2
`define RSS_MODE_XT 2'h1
`define RSS_MODE_LP 2'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define RSS_CLK_MHZ 200
`define RSS_POWER_UP_DELAY_TIMER_MS 72
`define RSS_POWER_UP_DELAY_TIMER_CYC (`RSS_POWER_UP_DELAY_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_OST_CYC 512
`define RSS_OST_LIMIT 704
`define RSS_IDLE_BITS 1408
`define RSS_RST_FILT_CYC 16

`endif

// ==== rss_pkg.sv ====
/*
 types shared by the reset and sleep sequencer files.
 assumes rss_consts.svh is included by each user.
*/
package rss_pkg;
    typedef enum logic [1:0] {
        RSS_LP,
        RSS_XT,
        RSS_EC,
        RSS_HS
    } rss_osc_mode_e;

    typedef struct packed {
        logic adc_run;
        logic auto_conv;
        logic auto_msg;
        logic pwm_run;
        logic clk_out;
    } rss_func_en_s;
endpackage

// ==== rss_sync.sv ====
/*
 two flip-flop synchroniser for one pin level.
 assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module rss_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic meta;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= INIT;
            level <= INIT;
        end else begin
            meta <= pin;
            level <= meta;
        end
    end
endmodule

// ==== rss_rst_filter.sv ====
/*
 glitch filter for the external reset pin: a low level must stand for
 LEN cycles before it is passed on. input is already synchronised.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_rst_filter
    import rss_pkg::*;
#(
    parameter int LEN = `RSS_RST_FILT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_low,
    output logic rst_req
);
    logic [$clog2(LEN+1)-1:0] cnt;

    // short pulses never reach the count, so they are dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            rst_req <= 1'b0;
        end else if (!pin_low) begin
            cnt <= '0;
            rst_req <= 1'b0;
        end else if (cnt == ($clog2(LEN+1))'(LEN - 1)) begin
            rst_req <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// ==== rss_seq.sv ====
/*
 reset and sleep sequencer top: power-up delay, oscillator settle delay,
 filtered external reset, sleep entry on bus idle or at power-up, and
 wake-up from gpio change, bus activity or external reset.
 assumes rst_n is the power-on reset and bus_bit_tick pulses once per
 can bit time on sys_clk.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_seq
    import rss_pkg::*;
#(
    parameter int POWER_UP_DELAY_TIMER_CYC = `RSS_POWER_UP_DELAY_TIMER_CYC,
    parameter int OST_CYC = `RSS_OST_CYC,
    parameter int IDLE_BITS = `RSS_IDLE_BITS,
    parameter int RST_FILT = `RSS_RST_FILT_CYC,
    parameter int NGPIO = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // programming access to the option word
    input wire logic prog_mode,
    input wire logic [15:0] prog_addr,
    input wire logic prog_wr,
    input wire logic [`RSS_OPT_W-1:0] prog_wdata,
    output logic [`RSS_OPT_W-1:0] prog_rdata,
    // option bits from option_reg_two
    input wire logic sleep_enable_bit,
    input wire logic powerup_sleep_enable,
    input wire logic global_irq_enable,
    // pins and bus
    input wire logic gpio_pin_seven,
    input wire logic [NGPIO-1:0] gpio_in,
    input wire logic [NGPIO-1:0] gpio_change_en,
    input wire logic can_rx,
    input wire logic bus_bit_tick,
    input wire logic msg_valid,
    // pin state to hold over sleep
    input wire logic [NGPIO-1:0] gpio_out_live,
    input wire logic [NGPIO-1:0] gpio_oe_live,
    output logic [NGPIO-1:0] gpio_out,
    output logic [NGPIO-1:0] gpio_oe,
    // status and control
    output logic dev_rst_n,
    output logic soft_rst_n,
    output logic asleep,
    output logic listen_only,
    output logic drop_wake_msg,
    output rss_osc_mode_e osc_mode,
    output logic ext_reset_pin_enable,
    output rss_func_en_s func_en
);
    // ------------------------------------------------------------------
    // option word
    // ------------------------------------------------------------------
    // held over every reset but power-on; no reset value on power-on
    // is modelled as erased since x cannot be synthesised
    logic [`RSS_OPT_W-1:0] device_option_word;
    logic opt_sel;

    assign opt_sel = prog_mode && (prog_addr == `RSS_OPT_ADDR);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            device_option_word <= `RSS_OPT_ERASED;
        end else if (opt_sel && prog_wr) begin
            // only mode and pin enable take the write; the reserved
            // field keeps its stored bits and the top bits stay zero
            device_option_word <= (prog_wdata & `RSS_OPT_USED_MASK)
                | (device_option_word & `RSS_OPT_RSVD_MASK);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata <= '0;
        end else if (opt_sel) begin
            prog_rdata <= device_option_word;
        end else begin
            prog_rdata <= '0;
        end
    end

    assign osc_mode = rss_osc_mode_e'(
        device_option_word[`RSS_OPT_MODE_HI:`RSS_OPT_MODE_LO]);
    assign ext_reset_pin_enable =
        device_option_word[`RSS_OPT_RST_BIT];

    // ------------------------------------------------------------------
    // pin synchronisers and reset filter
    // ------------------------------------------------------------------
    logic rst_pin_s;
    logic can_rx_s;
    logic [NGPIO-1:0] gpio_s;
    logic ext_rst_raw;
    logic ext_rst;

    rss_sync #(.INIT(1'b1)) u_rst_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(gpio_pin_seven),
        .level(rst_pin_s)
    );

    rss_sync #(.INIT(1'b1)) u_can_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin(can_rx),
        .level(can_rx_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NGPIO; gi++) begin : g_gpio
            rss_sync #(.INIT(1'b0)) u_gpio_sync (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .pin(gpio_in[gi]),
                .level(gpio_s[gi])
            );
        end
    endgenerate

    rss_rst_filter #(.LEN(RST_FILT)) u_filt (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_low(!rst_pin_s),
        .rst_req(ext_rst_raw)
    );

    assign ext_rst = ext_rst_raw && ext_reset_pin_enable;

    // ------------------------------------------------------------------
    // wake events
    // ------------------------------------------------------------------
    logic [NGPIO-1:0] gpio_d;
    logic can_d;
    logic gpio_wake;
    logic bus_wake;
    logic wake_req;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_d <= '0;
            can_d <= 1'b1;
        end else begin
            gpio_d <= gpio_s;
            can_d <= can_rx_s;
        end
    end

    // irq enable deliberately not in this term
    assign gpio_wake = |((gpio_s ^ gpio_d) & gpio_change_en);
    assign bus_wake = can_d && !can_rx_s;
    // a pin reset is not a wake here; it takes the reset hold path
    assign wake_req = gpio_wake || bus_wake;

    // ------------------------------------------------------------------
    // counter sizes
    // ------------------------------------------------------------------
    // a settle count at or above the limit would outlast the shortest
    // frame after a bus wake, so it is clipped just below it
    localparam int OST_USE = (OST_CYC < `RSS_OST_LIMIT) ? OST_CYC
        : `RSS_OST_LIMIT - 1;
    // one counter times both delays, so it is sized for the longer one
    localparam int SEQ_MAX = (POWER_UP_DELAY_TIMER_CYC > OST_USE) ? POWER_UP_DELAY_TIMER_CYC : OST_USE;
    localparam int SEQ_W = $clog2(SEQ_MAX + 1);
    localparam int IDLE_W = $clog2(IDLE_BITS + 1);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POWER_UP_DELAY_TIMER,
        ST_OST,
        ST_RUN,
        ST_SLEEP,
        ST_RSTHOLD
    } rss_state_e;

    rss_state_e state;
    rss_state_e next_state;
    logic [SEQ_W-1:0] cnt;
    logic [IDLE_W-1:0] idle_cnt;
    logic pu_listen;
    logic bus_idle_long;
    logic power_up_delay_timer_done;
    logic ost_done;

    assign power_up_delay_timer_done = cnt == SEQ_W'(POWER_UP_DELAY_TIMER_CYC - 1);
    assign ost_done = cnt == SEQ_W'(OST_USE - 1);
    assign bus_idle_long =
        idle_cnt == IDLE_W'(IDLE_BITS);

    always_comb begin
        next_state = state;
        case (state)
            ST_POWER_UP_DELAY_TIMER: begin
                if (power_up_delay_timer_done) begin
                    next_state = ST_OST;
                end
            end
            ST_OST: begin
                // a pin reset waits for the settle count, so the clock is not trusted
                // here before the crystal has settled; a pin reset in sleep skips the count
                if (ost_done && ext_rst) begin
                    next_state = ST_RSTHOLD;
                end else if (ost_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ext_rst) begin
                    next_state = ST_RSTHOLD;
                end else if (pu_listen && bus_idle_long) begin
                    next_state = ST_SLEEP;
                end else if (sleep_enable_bit && !pu_listen
                             && bus_idle_long) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (ext_rst) begin
                    next_state = ST_RSTHOLD;
                end else if (wake_req) begin
                    next_state = ST_OST;
                end
            end
            ST_RSTHOLD: begin
                // pin reset does not rerun the settle delay
                if (!ext_rst) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_POWER_UP_DELAY_TIMER;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_POWER_UP_DELAY_TIMER;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (next_state != state) begin
            cnt <= '0;
        end else if (state == ST_POWER_UP_DELAY_TIMER || state == ST_OST) begin
            cnt <= cnt + 1'b1;
        end
    end

    // idle counted in bit times while running; recessive means idle
    // saturates at the limit so a long idle never wraps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= '0;
        end else if (state != ST_RUN || !can_rx_s) begin
            idle_cnt <= '0;
        end else if (bus_bit_tick && !bus_idle_long) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // listen-only after power-up until one valid message is seen that is not dropped as the wake frame
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_listen <= 1'b0;
        end else if (state == ST_POWER_UP_DELAY_TIMER) begin
            pu_listen <= powerup_sleep_enable;
        end else if (state == ST_RUN && msg_valid && !drop_wake_msg) begin
            pu_listen <= 1'b0;
        end
    end

    // the frame that woke us is lost: drop the next valid message seen in run
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_wake_msg <= 1'b0;
        end else if (state == ST_SLEEP && bus_wake && !ext_rst) begin
            drop_wake_msg <= 1'b1;
        end else if (state == ST_RUN && msg_valid) begin
            drop_wake_msg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // pin hold and outputs
    // ------------------------------------------------------------------
    // last live drive is kept, so floating pins stay floating
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_out <= '0;
            gpio_oe <= '0;
        end else if (state != ST_SLEEP) begin
            gpio_out <= gpio_out_live;
            gpio_oe <= gpio_oe_live;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_rst_n <= 1'b0;
            soft_rst_n <= 1'b0;
            asleep <= 1'b0;
            listen_only <= 1'b0;
            func_en <= '0;
        end else begin
            // taken from the next state so each output but listen_only moves with it
            dev_rst_n <= (next_state == ST_RUN
                || next_state == ST_SLEEP);
            soft_rst_n <= (next_state != ST_RSTHOLD
                && next_state != ST_POWER_UP_DELAY_TIMER);
            asleep <= (next_state == ST_SLEEP);
            listen_only <= pu_listen;
            func_en <= {5{next_state == ST_RUN}};
        end
    end
endmodule

// ==== rss_props.sv ====
/*
 assertion checker for the reset and sleep sequencer top.
 assumes it is bound into rss_seq and sees only its ports.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_props
    import rss_pkg::*;
#(
    parameter int POWER_UP_DELAY_TIMER_CYC = 100,
    parameter int OST_CYC = 512,
    parameter int RST_FILT = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic prog_mode,
    input wire logic [15:0] prog_addr,
    input wire logic prog_wr,
    input wire logic [13:0] prog_wdata,
    input wire logic [13:0] prog_rdata,
    input wire logic gpio_pin_seven,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_change_en,
    input wire logic can_rx,
    input wire logic msg_valid,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic dev_rst_n,
    input wire logic asleep,
    input wire logic drop_wake_msg,
    input wire rss_osc_mode_e osc_mode,
    input wire logic ext_reset_pin_enable,
    input wire rss_func_en_s func_en
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    int up_cnt;
    int low_cnt;
    int evt_cnt;
    logic [7:0] gpio_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 0;
        end else if (up_cnt < POWER_UP_DELAY_TIMER_CYC + OST_CYC) begin
            up_cnt <= up_cnt + 1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 0;
        end else if (!gpio_pin_seven && ext_reset_pin_enable) begin
            low_cnt <= (low_cnt < 1000) ? low_cnt + 1 : low_cnt;
        end else begin
            low_cnt <= 0;
        end
    end
    // any wake cause restarts; lenient so settle may sit inside asleep
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_q <= 8'h0;
            evt_cnt <= 0;
        end else begin
            gpio_q <= gpio_in;
            if (|((gpio_in ^ gpio_q) & gpio_change_en) || !can_rx ||
                (!gpio_pin_seven && ext_reset_pin_enable)) begin
                evt_cnt <= 0;
            end else if (evt_cnt < 2000) begin
                evt_cnt <= evt_cnt + 1;
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_opt;
        prog_mode && prog_wr && prog_addr == `RSS_OPT_ADDR;
    endsequence
    sequence s_rd_opt;
        prog_mode && prog_addr == `RSS_OPT_ADDR;
    endsequence
    chk_power_up_delay_timer_hold: assert property (
        up_cnt < POWER_UP_DELAY_TIMER_CYC + OST_CYC - 2 |-> !dev_rst_n)
        else $error("reset released before both delays");
    chk_pin_reset: assert property (
        low_cnt == RST_FILT + 6 |-> !dev_rst_n)
        else $error("long reset pin low gave no reset");
    chk_sleep_halt: assert property (
        asleep && $past(asleep) |-> func_en == 5'h0)
        else $error("function still enabled in sleep");
    chk_pins_hold: assert property (
        asleep && $past(asleep) |-> $stable(gpio_out) && $stable(gpio_oe))
        else $error("pin state moved in sleep");
    chk_mode_write: assert property (
        s_wr_opt |=> {ext_reset_pin_enable, osc_mode} ==
            3'($past(prog_wdata)))
        else $error("option mode bits not applied");
    chk_rsvd_kept: assert property (
        s_wr_opt ##1 s_rd_opt |=> prog_rdata[13:3] == 11'h0ff)
        else $error("reserved or unused option bits changed");
    chk_read_gate: assert property (
        !prog_mode || prog_addr != `RSS_OPT_ADDR |=> prog_rdata == 14'h0)
        else $error("option word visible outside programming");
    chk_wake_cause: assert property (
        $fell(asleep) |-> evt_cnt < OST_CYC + 16)
        else $error("wake without a wake event");
    chk_drop_clear: assert property (
        drop_wake_msg && msg_valid && &func_en |=> !drop_wake_msg)
        else $error("wake message marker not cleared");
endmodule

// ==== rss_partner.sv ====
/*
 far side model: board reset line, can bus and bit pacing.
 assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/1ps
module rss_partner (
    input wire logic sys_clk,
    output logic gpio_pin_seven,
    output logic can_rx,
    output logic bus_bit_tick,
    output logic msg_valid
);
    logic [1:0] div = 2'h0;
    // pulled-up lines: released means high / recessive
    initial begin
        gpio_pin_seven = 1'h1;
        can_rx = 1'h1;
        msg_valid = 1'h0;
        bus_bit_tick = 1'h0;
    end
    // one bit time is four clocks, kept short for run time
    always @(posedge sys_clk) begin
        div <= div + 2'h1;
        bus_bit_tick <= (div == 2'h3);
    end
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rst_pulse(int len);
        gpio_pin_seven = 1'h0;
        step(len);
        gpio_pin_seven = 1'h1;
    endtask
    // dominant first and last bit so idle starts at the end
    task automatic frame(int bits);
        for (int i = 0; i < bits; i++) begin
            can_rx = (i == 0 || i == bits - 1) ? 1'h0 : 1'($urandom);
            step(4);
        end
        can_rx = 1'h1;
    endtask
    task automatic msg_ok;
        msg_valid = 1'h1;
        step(1);
        msg_valid = 1'h0;
    endtask
endmodule

// ==== tb_top.sv ====
/*
 self-checking bench for the reset and sleep sequencer.
 assumes short power-up and idle counts set by parameter.
*/
`timescale 1ns/1ps
`include "rss_consts.svh"
module tb_top;
    import rss_pkg::*;
    localparam int PW = 100;
    localparam int OS = 512;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic prog_mode = 1'h0;
    logic prog_wr = 1'h0;
    logic [15:0] prog_addr = 16'h0;
    logic [13:0] prog_wdata = 14'h0;
    logic [13:0] prog_rdata;
    logic sleep_enable_bit = 1'h0;
    logic powerup_sleep_enable = 1'h0;
    logic global_irq_enable = 1'h0;
    logic [7:0] gpio_in = 8'h0;
    logic [7:0] gpio_change_en = 8'h0;
    logic [7:0] gpio_out_live = 8'h0;
    logic [7:0] gpio_oe_live = 8'h0;
    logic [7:0] gpio_out, gpio_oe;
    logic gpio_pin_seven, can_rx, bus_bit_tick, msg_valid;
    logic dev_rst_n, soft_rst_n, asleep, listen_only, drop_wake_msg;
    logic ext_reset_pin_enable;
    logic [15:0] held;
    rss_osc_mode_e osc_mode;
    rss_func_en_s func_en;
    int mismatches = 0;
    int compares = 0;
    int n;
    int exp_opt = 'h7ff;
    rss_seq #(.POWER_UP_DELAY_TIMER_CYC(PW), .IDLE_BITS(8)) dut_u (.sys_clk, .rst_n,
        .prog_mode, .prog_addr, .prog_wr, .prog_wdata, .prog_rdata,
        .sleep_enable_bit, .powerup_sleep_enable, .global_irq_enable,
        .gpio_pin_seven, .gpio_in, .gpio_change_en, .can_rx,
        .bus_bit_tick, .msg_valid, .gpio_out_live, .gpio_oe_live,
        .gpio_out, .gpio_oe, .dev_rst_n, .soft_rst_n, .asleep,
        .listen_only, .drop_wake_msg, .osc_mode, .ext_reset_pin_enable,
        .func_en);
    rss_partner bus_u (.sys_clk, .gpio_pin_seven, .can_rx, .bus_bit_tick,
        .msg_valid);
    always #2.5 sys_clk = ~sys_clk;
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test;
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic sig(int k);
        case (k)
            0: return dev_rst_n;
            1: return asleep;
            default: return &func_en;
        endcase
    endfunction
    task automatic wait_for(int k, logic v, output int c);
        c = 0;
        while (sig(k) !== v && c < 4000) begin
            cyc(1);
            c++;
        end
    endtask
    task automatic opt_wr(logic md, logic [13:0] d);
        prog_mode = md;
        prog_addr = `RSS_OPT_ADDR;
        prog_wdata = d;
        prog_wr = 1'h1;
        if (md) exp_opt = 'h7f8 | (d & 14'h7);
        cyc(1);
        prog_wr = 1'h0;
    endtask
    task automatic opt_rd(logic md, logic [15:0] a, logic [13:0] e);
        prog_mode = md;
        prog_addr = a;
        cyc(1);
        chk(prog_rdata, e);
    endtask
    task automatic pin_rst(int len, output int lows);
        lows = 0;
        fork
            bus_u.rst_pulse(len);
            repeat (len + 25) begin
                cyc(1);
                lows += (dev_rst_n !== 1'h1);
            end
        join
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hb09f8b29));
        cyc(12);
        rst_n = 1'h1;
        wait_for(0, 1'h1, n);
        chk(n >= PW + OS && n <= PW + OS + 4, 1);
        opt_rd(1'h1, `RSS_OPT_ADDR, 14'h7ff);
        chk(osc_mode, RSS_HS);
        opt_rd(1'h1, 16'h2006, 14'h0);
        for (int m = 0; m < 4; m++) begin
            opt_wr(1'h1, {3'h7, 8'($urandom), 3'(m) | 3'h4});
            chk(osc_mode, m);
            opt_rd(1'h1, `RSS_OPT_ADDR, exp_opt[13:0]);
        end
        opt_wr(1'h0, 14'h0);
        opt_rd(1'h0, `RSS_OPT_ADDR, 14'h0);
        opt_rd(1'h1, `RSS_OPT_ADDR, exp_opt[13:0]);
        cyc(60);
        chk(asleep, 0);
        gpio_out_live = 8'($urandom);
        gpio_oe_live = 8'($urandom);
        held = {gpio_oe_live, gpio_out_live};
        bus_u.frame(6);
        // enabled only now: the bus already idled long enough above
        sleep_enable_bit = 1'h1;
        wait_for(1, 1'h1, n);
        chk(n >= 28 && n <= 44, 1);
        gpio_out_live = ~gpio_out_live;
        gpio_oe_live = ~gpio_oe_live;
        cyc(3);
        chk({gpio_oe, gpio_out}, held);
        chk(func_en, 0);
        gpio_change_en = 8'h01;
        global_irq_enable = 1'($urandom);
        gpio_in[1] = 1'h1;
        cyc(20);
        chk(asleep, 1);
        gpio_in[0] = 1'h1;
        wait_for(2, 1'h1, n);
        chk(n >= OS && n < 704, 1);
        wait_for(1, 1'h1, n);
        sleep_enable_bit = 1'h0;
        bus_u.frame(4);
        chk(drop_wake_msg, 1);
        wait_for(2, 1'h1, n);
        chk(soft_rst_n, 1);
        bus_u.msg_ok;
        cyc(2);
        chk(drop_wake_msg, 0);
        pin_rst(3 + $urandom % 12, n);
        chk(n, 0);
        pin_rst(40, n);
        chk(n >= 18 && n <= 30, 1);
        opt_wr(1'h1, 14'h7fb);
        chk(ext_reset_pin_enable, 0);
        pin_rst(40, n);
        chk(n, 0);
        powerup_sleep_enable = 1'h1;
        rst_n = 1'h0;
        cyc(3);
        rst_n = 1'h1;
        wait_for(1, 1'h1, n);
        chk({asleep, listen_only}, 2'h3);
        bus_u.frame(4);
        wait_for(1, 1'h0, n);
        cyc(OS);
        bus_u.msg_ok;
        cyc(2);
        chk(listen_only, 1);
        bus_u.msg_ok;
        cyc(3);
        chk(listen_only, 0);
        stop_test;
    end
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end
endmodule
bind rss_seq rss_props #(.POWER_UP_DELAY_TIMER_CYC(POWER_UP_DELAY_TIMER_CYC), .OST_CYC(OST_CYC),
    .RST_FILT(RST_FILT)) props_u (.sys_clk, .rst_n, .prog_mode,
    .prog_addr, .prog_wr, .prog_wdata, .prog_rdata, .gpio_pin_seven,
    .gpio_in, .gpio_change_en, .can_rx, .msg_valid, .gpio_out, .gpio_oe,
    .dev_rst_n, .asleep, .drop_wake_msg, .osc_mode, .ext_reset_pin_enable,
    .func_en);
